// file: sim/wocb_config_checker.sv
`timescale 1ns/1ps
`include "wocb_map.vh"
module wocb_config_checker (
   input wire clk,
   input wire reset_n,
   input wire pm_req_r,
   input wire [1:0] pm_index_r,
   input wire pm_ack,
   input wire [7:0] pm_data,
   input wire [25:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire config_loaded_r,
   input wire code_protect_r,
   input wire clock_monitor_enable_r,
   input wire two_speed_startup_enable_r,
   input wire [3:0] watchdog_postscale_select_r,
   input wire [15:0] watchdog_ratio_onehot_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   reg [25:0] ra_r;
   reg [1:0] chg_r;
   wire ld = pm_req_r && pm_ack;
   // counts postscale changes once loading is over
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ra_r <= 26'h0;
         chg_r <= 2'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
         if ($past(config_loaded_r, 2) && $changed(watchdog_postscale_select_r) && chg_r != 2'h3)
            chg_r <= chg_r + 2'h1;
      end
   end
   a_cp_polarity:
      assert property (ld && pm_index_r == 2'h1 |-> ##2 code_protect_r == !$past(pm_data[2], 2))
      else $error("code protect not inverse of loaded bit");
   a_monitor_load:
      assert property (ld && pm_index_r == 2'h2
         |-> ##2 clock_monitor_enable_r == $past(pm_data[6], 2))
      else $error("clock monitor enable wrong");
   a_two_speed_load:
      assert property (ld && pm_index_r == 2'h2
         |-> ##2 two_speed_startup_enable_r == $past(pm_data[7], 2))
      else $error("two speed enable wrong");
   a_rst_ones:
      assert property ($rose(reset_n) |-> watchdog_postscale_select_r == 4'hf && !code_protect_r
         && clock_monitor_enable_r && two_speed_startup_enable_r)
      else $error("power-on values not all ones");
   a_load_order:
      assert property (ld && pm_index_r != 2'h3 |=> !pm_req_r ##1 pm_req_r
         && pm_index_r == $past(pm_index_r, 2) + 2'h1)
      else $error("load order wrong");
   a_loaded_after:
      assert property (ld && pm_index_r == 2'h3 |-> ##[1:2] config_loaded_r)
      else $error("loaded flag late");
   a_onehot_ratio:
      assert property (watchdog_ratio_onehot_r == 16'h1 << watchdog_postscale_select_r)
      else $error("ratio not power of two of select");
   a_read_unused:
      assert property (s_axi_rvalid && ra_r == `WOCB_ADDR_CODE_PROTECT
         |-> (s_axi_rdata & ~32'h4) == 32'h0)
      else $error("unimplemented bits read nonzero");
   a_lock_keeps:
      assert property (chg_r <= 2'h1)
      else $error("locked postscale changed twice");
endmodule // wocb_config_checker
bind wocb_config wocb_config_checker wocb_config_checker_i (.*);

// file: sim/wocb_pm_model.sv
`timescale 1ns/1ps
module wocb_pm_model (
   // load path
   input wire clk,
   input wire pm_req_r,
   input wire [1:0] pm_index_r,
   output reg pm_ack = 1'b0,
   output reg [7:0] pm_data = 8'h00,
   // stored image and answer delay
   input wire [23:0] image,
   input wire [2:0] slow
);
   integer w = 0;
   always @(posedge clk) begin
      pm_ack <= 1'b0;
      pm_data <= ~pm_data;
      if (pm_req_r && !pm_ack) begin
         if (w >= slow) begin
            pm_ack <= 1'b1;
            w <= 0;
            case (pm_index_r)
               2'h1: pm_data <= {4'hf, 1'b0, image[2:0]};
               2'h2: pm_data <= image[15:8];
               default: pm_data <= {4'hf, image[19:16]};
            endcase
         end else begin
            w <= w + 1;
         end
      end
   end
endmodule // wocb_pm_model

// file: sim/write_once_config_bytes_test.sv
`timescale 1ns/1ps
`include "wocb_map.vh"
module write_once_config_bytes_test;
   reg clk = 0, reset_n = 0;
   reg [25:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   reg [31:0] s_axi_wdata = 0;
   reg [3:0] s_axi_wstrb = 0;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   wire pm_req_r, pm_ack, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] pm_index_r, s_axi_bresp, s_axi_rresp;
   wire [7:0] pm_data;
   wire [31:0] s_axi_rdata;
   wire config_loaded_r, code_protect_r, clock_monitor_enable_r, two_speed_startup_enable_r;
   wire low_power_sosc_r, timer1_digital_input_r;
   wire [2:0] primary_osc_select_r;
   wire [3:0] watchdog_postscale_select_r;
   wire [15:0] watchdog_ratio_onehot_r;
   reg [2:0] slow = 0;
   reg [7:0] v [1:3];
   reg [7:0] nv, nx;
   reg [7:0] nw [1:3];
   wire [23:0] image = {v[3], v[2], v[1]};
   integer bad_count = 0, n_compared = 0, t, i;
   wocb_config wocb_config_i (.*);
   wocb_pm_model wocb_pm_model_i (.*);
   initial forever #5 clk = ~clk;
   task chk(input [31:0] s, input [31:0] e);
      begin
         n_compared = n_compared + 1;
         if (s !== e) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   function [25:0] ad(input integer k);
      ad = 26'h0c00000 + 26'(k * 4);
   endfunction
   function [31:0] mk(input integer k, input [7:0] x);
      mk = {24'h0, x & (k == 1 ? `WOCB_CP_MASK : k == 2 ? `WOCB_CS_MASK : `WOCB_WS_MASK)};
   endfunction
   task wr(input [25:0] a, input [7:0] d, input [3:0] s, input [1:0] r);
      begin
         @(posedge clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h0, d};
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (s_axi_bvalid !== 1'b1);
         s_axi_bready <= 1'b0;
         chk(s_axi_bresp, r);
      end
   endtask
   task rd(input [25:0] a, input [31:0] e, input [1:0] r);
      begin
         @(posedge clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1);
         s_axi_rready <= 1'b0;
         chk(s_axi_rdata, e);
         chk(s_axi_rresp, r);
      end
   endtask
   task results;
      begin
         $display("compared %0d bad %0d", n_compared, bad_count);
         if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      #300000;
      bad_count = bad_count + 1;
      results;
   end
   initial begin
      void'($urandom(32'heb2da4d9));
      for (t = 0; t < 3; t = t + 1) begin
         v[1] = {4'hf, 1'b0, t[0], 2'b11};
         v[2] = $urandom;
         v[3] = {4'hf, (t == 0) ? 4'h9 : 4'($urandom)};
         slow <= $urandom;
         reset_n <= 1'b0;
         repeat (5) @(posedge clk);
         reset_n <= 1'b1;
         for (i = 0; i < 300 && config_loaded_r !== 1'b1; i = i + 1) @(posedge clk);
         for (i = 1; i < 4; i = i + 1) rd(ad(i), mk(i, v[i]), `WOCB_RESP_OKAY);
         chk(code_protect_r, !v[1][2]);
         chk({two_speed_startup_enable_r, clock_monitor_enable_r, low_power_sosc_r,
            timer1_digital_input_r, primary_osc_select_r}, {v[2][7:6], v[2][4:0]});
         chk(watchdog_ratio_onehot_r, 32'h1 << v[3][3:0]);
         chk(config_loaded_r, 1'b1);
         rd(`WOCB_ADDR_STATUS, 32'h1, `WOCB_RESP_OKAY);
         rd(26'h0c00010, 32'h0, `WOCB_RESP_SLVERR);
         wr(26'h0c00014, 8'h00, 4'h1, `WOCB_RESP_SLVERR);
         wr(`WOCB_ADDR_STATUS, 8'hff, 4'h1, `WOCB_RESP_OKAY);
         rd(`WOCB_ADDR_STATUS, 32'h1, `WOCB_RESP_OKAY);
         for (i = 1; i < 4; i = i + 1) begin
            nv = $urandom & (i == 1 ? 8'hf7 : 8'hff);
            nx = ~nv & (i == 1 ? 8'hf7 : 8'hff);
            nw[i] = nv;
            wr(ad(i), nx, 4'h0, `WOCB_RESP_OKAY);
            wr(ad(i), nv, 4'h1, `WOCB_RESP_OKAY);
            wr(ad(i), nx, 4'h1, `WOCB_RESP_OKAY);
            rd(ad(i), mk(i, nv), `WOCB_RESP_OKAY);
         end
         rd(`WOCB_ADDR_STATUS, 32'hf, `WOCB_RESP_OKAY);
         chk(code_protect_r, !nw[1][2]);
         chk({two_speed_startup_enable_r, clock_monitor_enable_r, low_power_sosc_r,
            timer1_digital_input_r, primary_osc_select_r}, {nw[2][7:6], nw[2][4:0]});
         chk(watchdog_postscale_select_r, nv[3:0]);
         chk(watchdog_ratio_onehot_r, 32'h1 << nv[3:0]);
         $display("test %0d done", t);
      end
      results;
   end
endmodule // write_once_config_bytes_test

// file: verilog/wocb_config.v
// Contract
// - code protect bit 1 leaves program memory open, 0 protects it
// - unimplemented bits 7-3 and 1-0 of code protect byte read zero
// - implemented bits write-once, read 1 unprogrammed; unimplemented bits read zero
// - watchdog postscale field selects power-of-two ratio, 1111 the largest
// - configuration words copied from program memory automatically at power-up
// - bits reset to 1 on power-on reset, kept over other resets
// - programmed bit rejects further writes until power is cycled
`timescale 1ns/1ps
`include "wocb_map.vh"

module wocb_config (
   // clock and power-on reset
   input wire clk,
   input wire reset_n,
   // program memory configuration load path
   output reg pm_req_r,
   output reg [1:0] pm_index_r,
   input wire pm_ack,
   input wire [7:0] pm_data,
   // axi4-lite write address
   input wire [`WOCB_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [`WOCB_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // configuration outputs
   output reg config_loaded_r,
   output reg code_protect_r,
   output reg clock_monitor_enable_r,
   output reg two_speed_startup_enable_r,
   output reg low_power_sosc_r,
   output reg timer1_digital_input_r,
   output reg [2:0] primary_osc_select_r,
   output reg [3:0] watchdog_postscale_select_r,
   output reg [15:0] watchdog_ratio_onehot_r
);

   localparam LD_REQ = 2'h0;
   localparam LD_WAIT = 2'h1;
   localparam LD_DONE = 2'h2;

   // power-on bytes, source of the decoded output reset values
   localparam [`WOCB_CFG_W-1:0] CP_POR = `WOCB_CP_RESET;
   localparam [`WOCB_CFG_W-1:0] CS_POR = `WOCB_CS_RESET;
   localparam [`WOCB_CFG_W-1:0] WS_POR = `WOCB_WS_RESET;

   reg [1:0] ld_state_r;
   reg [7:0] code_protect_config_r;
   reg [7:0] clock_source_config_r;
   reg [7:0] watchdog_scale_config_r;
   reg [7:0] cp_lock_r;
   reg [7:0] cs_lock_r;
   reg [7:0] ws_lock_r;

   reg aw_held_r;
   reg w_held_r;
   reg [`WOCB_ADDR_W-1:0] aw_addr_r;
   reg [7:0] w_byte_r;
   reg w_lane_r;

   wire do_write;
   wire wr_cp;
   wire wr_cs;
   wire wr_ws;
   wire wr_hit;
   wire [7:0] cp_nxt;
   wire [7:0] cs_nxt;
   wire [7:0] ws_nxt;
   wire [`WOCB_CFG_N*`WOCB_CFG_W-1:0] cfg_now;
   wire [`WOCB_CFG_N*`WOCB_CFG_W-1:0] cfg_lock;
   wire [`WOCB_CFG_N*`WOCB_CFG_W-1:0] cfg_mask;
   wire [`WOCB_CFG_N*`WOCB_CFG_W-1:0] cfg_nxt;
   genvar gi;
   reg [7:0] rd_byte;
   reg rd_hit;

   // program memory load: one byte per index, unimplemented bits masked off
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ld_state_r <= LD_REQ;
         pm_req_r <= 1'b0;
         pm_index_r <= `WOCB_LD_FIRST;
         config_loaded_r <= 1'b0;
      end else begin
         case (ld_state_r)
            LD_REQ: begin
               pm_req_r <= 1'b1;
               ld_state_r <= LD_WAIT;
            end
            LD_WAIT: begin
               if (pm_ack) begin
                  pm_req_r <= 1'b0;
                  if (pm_index_r == `WOCB_LD_LAST) begin
                     ld_state_r <= LD_DONE;
                     config_loaded_r <= 1'b1;
                  end else begin
                     pm_index_r <= pm_index_r + 2'h1;
                     ld_state_r <= LD_REQ;
                  end
               end
            end
            default: begin
               ld_state_r <= LD_DONE;
            end
         endcase
      end
   end

   // bus write: address and data taken in either order, done once both are held
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_cp = do_write && w_lane_r && (aw_addr_r == `WOCB_ADDR_CODE_PROTECT);
   assign wr_cs = do_write && w_lane_r && (aw_addr_r == `WOCB_ADDR_CLOCK_SOURCE);
   assign wr_ws = do_write && w_lane_r && (aw_addr_r == `WOCB_ADDR_WATCHDOG_SCALE);
   assign wr_hit = (aw_addr_r == `WOCB_ADDR_CODE_PROTECT) ||
                   (aw_addr_r == `WOCB_ADDR_CLOCK_SOURCE) ||
                   (aw_addr_r == `WOCB_ADDR_WATCHDOG_SCALE) ||
                   (aw_addr_r == `WOCB_ADDR_STATUS);

   // locked bits keep their value, unimplemented bits stay zero
   assign cfg_now = {watchdog_scale_config_r, clock_source_config_r, code_protect_config_r};
   assign cfg_lock = {ws_lock_r, cs_lock_r, cp_lock_r};
   assign cfg_mask = {`WOCB_WS_MASK, `WOCB_CS_MASK, `WOCB_CP_MASK};
   generate
      for (gi = 0; gi < `WOCB_CFG_N; gi = gi + 1) begin : g_merge
         wire [`WOCB_CFG_W-1:0] now_b;
         wire [`WOCB_CFG_W-1:0] lock_b;
         wire [`WOCB_CFG_W-1:0] mask_b;
         assign now_b = cfg_now[gi*`WOCB_CFG_W +: `WOCB_CFG_W];
         assign lock_b = cfg_lock[gi*`WOCB_CFG_W +: `WOCB_CFG_W];
         assign mask_b = cfg_mask[gi*`WOCB_CFG_W +: `WOCB_CFG_W];
         assign cfg_nxt[gi*`WOCB_CFG_W +: `WOCB_CFG_W] =
            ((now_b & lock_b) | (w_byte_r & ~lock_b)) & mask_b;
      end
   endgenerate
   assign {ws_nxt, cs_nxt, cp_nxt} = cfg_nxt;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `WOCB_RESP_OKAY;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= {`WOCB_ADDR_W{1'b0}};
         w_byte_r <= 8'h00;
         w_lane_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (config_loaded_r && !aw_held_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (config_loaded_r && !w_held_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `WOCB_RESP_OKAY : `WOCB_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration storage, only power-on reset returns it to ones
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         code_protect_config_r <= `WOCB_CP_RESET;
         clock_source_config_r <= `WOCB_CS_RESET;
         watchdog_scale_config_r <= `WOCB_WS_RESET;
         cp_lock_r <= 8'h00;
         cs_lock_r <= 8'h00;
         ws_lock_r <= 8'h00;
      end else begin
         if (ld_state_r == LD_WAIT && pm_ack) begin
            // unimplemented bits from the loader are masked off
            case (pm_index_r)
               `WOCB_LD_FIRST: begin
                  code_protect_config_r <= pm_data & `WOCB_CP_MASK;
               end
               `WOCB_LD_LAST: begin
                  watchdog_scale_config_r <= pm_data & `WOCB_WS_MASK;
               end
               default: begin
                  clock_source_config_r <= pm_data & `WOCB_CS_MASK;
               end
            endcase
         end
         if (wr_cp) begin
            code_protect_config_r <= cp_nxt;
            cp_lock_r <= `WOCB_CP_MASK;
         end
         if (wr_cs) begin
            clock_source_config_r <= cs_nxt;
            cs_lock_r <= `WOCB_CS_MASK;
         end
         if (wr_ws) begin
            watchdog_scale_config_r <= ws_nxt;
            ws_lock_r <= `WOCB_WS_MASK;
         end
      end
   end

   // read decode
   always @* begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      if (s_axi_araddr == `WOCB_ADDR_CODE_PROTECT) begin
         rd_byte = code_protect_config_r & `WOCB_CP_MASK;
      end else if (s_axi_araddr == `WOCB_ADDR_CLOCK_SOURCE) begin
         rd_byte = clock_source_config_r & `WOCB_CS_MASK;
      end else if (s_axi_araddr == `WOCB_ADDR_WATCHDOG_SCALE) begin
         rd_byte = watchdog_scale_config_r & `WOCB_WS_MASK;
      end else if (s_axi_araddr == `WOCB_ADDR_STATUS) begin
         rd_byte[`WOCB_ST_LOADED] = config_loaded_r;
         rd_byte[`WOCB_ST_CP_LOCK] = |cp_lock_r;
         rd_byte[`WOCB_ST_CS_LOCK] = |cs_lock_r;
         rd_byte[`WOCB_ST_WS_LOCK] = |ws_lock_r;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `WOCB_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? `WOCB_RESP_OKAY : `WOCB_RESP_SLVERR;
         end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // decoded configuration outputs
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         code_protect_r <= ~CP_POR[`WOCB_CP_BIT];
         clock_monitor_enable_r <= CS_POR[`WOCB_CS_MONITOR];
         two_speed_startup_enable_r <= CS_POR[`WOCB_CS_TWO_SPEED];
         low_power_sosc_r <= CS_POR[`WOCB_CS_LP_SOSC];
         timer1_digital_input_r <= CS_POR[`WOCB_CS_T1_DIGITAL];
         primary_osc_select_r <= CS_POR[`WOCB_CS_OSC_HI:`WOCB_CS_OSC_LO];
         watchdog_postscale_select_r <= WS_POR[`WOCB_WS_PS_HI:`WOCB_WS_PS_LO];
         watchdog_ratio_onehot_r <= 16'h0001 << WS_POR[`WOCB_WS_PS_HI:`WOCB_WS_PS_LO];
      end else begin
         // active-high protect from an active-low stored bit
         code_protect_r <= ~code_protect_config_r[`WOCB_CP_BIT];
         clock_monitor_enable_r <= clock_source_config_r[`WOCB_CS_MONITOR];
         two_speed_startup_enable_r <= clock_source_config_r[`WOCB_CS_TWO_SPEED];
         low_power_sosc_r <= clock_source_config_r[`WOCB_CS_LP_SOSC];
         timer1_digital_input_r <= clock_source_config_r[`WOCB_CS_T1_DIGITAL];
         primary_osc_select_r <=
            clock_source_config_r[`WOCB_CS_OSC_HI:`WOCB_CS_OSC_LO];
         watchdog_postscale_select_r <=
            watchdog_scale_config_r[`WOCB_WS_PS_HI:`WOCB_WS_PS_LO];
         // ratio 1:2^n as a one-hot tap select
         watchdog_ratio_onehot_r <= 16'h0001 <<
            watchdog_scale_config_r[`WOCB_WS_PS_HI:`WOCB_WS_PS_LO];
      end
   end

endmodule // wocb_config

// file: verilog/wocb_map.vh
`ifndef WOCB_MAP_VH
`define WOCB_MAP_VH

// register indices; byte address on the bus is four times the index
`define WOCB_IDX_CODE_PROTECT 24'h300001
`define WOCB_IDX_CLOCK_SOURCE 24'h300002
`define WOCB_IDX_WATCHDOG_SCALE 24'h300003
`define WOCB_IDX_STATUS 24'h300006
`define WOCB_ADDR_CODE_PROTECT 26'h0c00004
`define WOCB_ADDR_CLOCK_SOURCE 26'h0c00008
`define WOCB_ADDR_WATCHDOG_SCALE 26'h0c0000c
`define WOCB_ADDR_STATUS 26'h0c00018
`define WOCB_ADDR_W 26

// implemented bit masks; power-on value of every implemented bit is 1
`define WOCB_CP_MASK 8'h04
`define WOCB_CS_MASK 8'hdf
`define WOCB_WS_MASK 8'h0f
`define WOCB_CP_RESET 8'h04
`define WOCB_CS_RESET 8'hdf
`define WOCB_WS_RESET 8'h0f

// field positions
`define WOCB_CP_BIT 2
`define WOCB_CS_TWO_SPEED 7
`define WOCB_CS_MONITOR 6
`define WOCB_CS_LP_SOSC 4
`define WOCB_CS_T1_DIGITAL 3
`define WOCB_CS_OSC_HI 2
`define WOCB_CS_OSC_LO 0
`define WOCB_WS_PS_HI 3
`define WOCB_WS_PS_LO 0
`define WOCB_ST_LOADED 0
`define WOCB_ST_CP_LOCK 1
`define WOCB_ST_CS_LOCK 2
`define WOCB_ST_WS_LOCK 3

// width and count of the configuration bytes
`define WOCB_CFG_W 8
`define WOCB_CFG_N 3

// loader byte indices within the configuration words
`define WOCB_LD_FIRST 2'h1
`define WOCB_LD_LAST 2'h3

// bus answers
`define WOCB_RESP_OKAY 2'h0
`define WOCB_RESP_SLVERR 2'h2

`endif
